// ==== core/ocd_pkg.sv ====
// How it works
// - Startup clock from byte one bits 7:6.
// - Detector bit zero enables low-voltage detector.
// - Watchdog bit zero means always-on watchdog.
// - Halt-reset bit one resets on Halt entry.
// - Byte zero top bit picks wakeup clock.
// - Range field picks resonator current band.
// - Boot region size from byte zero bits 3:2.
// - Read-out protect blocks extraction and flash writes.
// - Erasing protected options erases program memory first.
// - Write protect refuses every erase and program.
// - Option bytes reachable only in programming mode.
// - Blank program memory holds FFh everywhere.
package ocd_pkg;

    // ==========================================================
    // Values after erase and field positions
    // ==========================================================

    // Contents of the two configuration bytes as delivered.
    localparam logic [7:0] CFG0_RESET = 8'hFC;
    localparam logic [7:0] CFG1_RESET = 8'h3F;
    // Value that every blank program memory byte holds.
    localparam logic [7:0] MEM_BLANK_BYTE = 8'hFF;

    // Field positions in configuration byte one.
    localparam int CFG1_CLK_HI = 7;
    localparam int CFG1_CLK_LO = 6;
    localparam int CFG1_LVD_BIT = 2;
    localparam int CFG1_WDG_TYPE_BIT = 1;
    localparam int CFG1_WATCHDOG_HALT_RESET_BIT = 0;
    // Field positions in configuration byte zero.
    localparam int CFG0_WAKE_BIT = 7;
    localparam int CFG0_RANGE_HI = 6;
    localparam int CFG0_RANGE_LO = 4;
    localparam int CFG0_BOOT_HI = 3;
    localparam int CFG0_BOOT_LO = 2;
    localparam int CFG0_RDP_BIT = 1;
    localparam int CFG0_WRP_BIT = 0;

    // ==========================================================
    // Encodings
    // ==========================================================

    // Startup clock source codes.
    localparam logic [1:0] CLK_INT_RC = 2'h0;
    localparam logic [1:0] CLK_WAKE_RC = 2'h1;
    localparam logic [1:0] CLK_RESONATOR = 2'h2;
    localparam logic [1:0] CLK_EXTERNAL = 2'h3;
    // Highest resonator range code, the 32.768 kHz watch crystal band.
    localparam logic [2:0] RANGE_WATCH = 3'h4;
    // Range code that has no use.
    localparam logic [2:0] RANGE_RESERVED = 3'h6;
    // Smallest boot region size in bytes; each code step doubles it.
    localparam logic [12:0] BOOT_BASE_BYTES = 13'h0200;
    // Byte select on the programming port.
    localparam logic SEL_BYTE1 = 1'b1;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_LOAD,
        ST_RUN,
        ST_NV_BUSY,
        ST_MEM_ERASE
    } ocd_state_type;

    // Decoded hardware settings.
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] range;
        logic resonator_on;
        logic ext_clock;
        logic range_rsv;
        logic lvd_en;
        logic wdg_always;
        logic halt_rst;
        logic wake_sel;
        logic [1:0] boot_sel;
        logic [12:0] boot_bytes;
        logic rdp;
        logic wrp;
        logic rd_block;
        logic wr_block;
    } ocd_cfg_type;

    // Turns the two raw bytes into settings.
    function automatic ocd_cfg_type ocd_decode(input logic [7:0] byte0, input logic [7:0] byte1);
        ocd_cfg_type d;
        d = '0;
        d.clk_sel = byte1[CFG1_CLK_HI:CFG1_CLK_LO];
        d.range = byte0[CFG0_RANGE_HI:CFG0_RANGE_LO];
        d.resonator_on = (d.clk_sel == CLK_RESONATOR) && (d.range <= RANGE_WATCH);
        d.ext_clock = (d.clk_sel == CLK_EXTERNAL) ||
            (d.clk_sel[1] && (d.range > RANGE_WATCH) && (d.range != RANGE_RESERVED));
        d.range_rsv = d.clk_sel[1] && (d.range == RANGE_RESERVED);
        d.lvd_en = ~byte1[CFG1_LVD_BIT];
        d.wdg_always = ~byte1[CFG1_WDG_TYPE_BIT];
        d.halt_rst = byte1[CFG1_WATCHDOG_HALT_RESET_BIT];
        d.wake_sel = byte0[CFG0_WAKE_BIT];
        d.boot_sel = byte0[CFG0_BOOT_HI:CFG0_BOOT_LO];
        d.boot_bytes = BOOT_BASE_BYTES << d.boot_sel;
        d.rdp = byte0[CFG0_RDP_BIT];
        d.wrp = byte0[CFG0_WRP_BIT];
        d.rd_block = d.rdp;
        d.wr_block = d.rdp | d.wrp;
        return d;
    endfunction

    // Settings that the delivered bytes give, shown while in reset.
    localparam ocd_cfg_type CFG_DEFAULT = ocd_decode(CFG0_RESET, CFG1_RESET);

endpackage

// ==== core/ocd_reset_sync.sv ====
// ==========================================================
// Reset release synchroniser
// ==========================================================
// Asserts at once and releases two clock edges after the pin.
module ocd_reset_sync
    import ocd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_rst_n
);

    // Two flip-flop stages of the release chain.
    typedef struct packed {
        logic stage1;
        logic stage2;
    } ocd_sync_state_type;

    ocd_sync_state_type sync_reg; // Registered chain.
    ocd_sync_state_type sync_next; // Next chain value.

    // The first stage feeds only the second stage.
    always_comb begin
        sync_next = sync_reg;
        sync_next.stage1 = 1'b1;
        sync_next.stage2 = sync_reg.stage1;
    end

    // Both stages clear asynchronously.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign o_rst_n = sync_reg.stage2;

endmodule // ocd_reset_sync

// ==== core/ocd_option_decoder.sv ====
// ==========================================================
// Configuration byte loader, decoder and programming gate
// ==========================================================
// The two bytes live in non-volatile cells outside this block.
// After reset the block copies them once and decodes them into
// static settings. A programming port reads, writes and erases
// the cells, guarded by mode and protection bits.
module ocd_option_decoder
    import ocd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_prog_mode,
    input wire logic i_opt_req,
    input wire logic i_opt_we,
    input wire logic i_opt_erase,
    input wire logic i_opt_sel,
    input wire logic [7:0] i_opt_wdata,
    input wire logic [7:0] i_nv_byte0,
    input wire logic [7:0] i_nv_byte1,
    input wire logic i_nv_done,
    output logic o_opt_ack,
    output logic o_opt_refused,
    output logic [7:0] o_opt_rdata,
    output logic o_nv_wr_en,
    output logic o_nv_wr_sel,
    output logic [7:0] o_nv_wr_data,
    output logic o_nv_opt_erase,
    output logic o_mem_erase,
    output logic [7:0] o_mem_fill,
    output logic o_config_valid,
    output logic [1:0] o_startup_clock_select,
    output logic [2:0] o_resonator_range,
    output logic o_resonator_enable,
    output logic o_external_clock,
    output logic o_range_reserved,
    output logic o_low_voltage_detect_enable,
    output logic o_watchdog_always_on,
    output logic o_watchdog_halt_reset,
    output logic o_wakeup_clock_select,
    output logic [1:0] o_boot_region_size,
    output logic [12:0] o_boot_region_bytes,
    output logic o_readout_protect,
    output logic o_program_write_protect,
    output logic o_mem_read_block,
    output logic o_mem_write_block
);

    // ==========================================================
    // State
    // ==========================================================

    // Every flip-flop of the block.
    typedef struct packed {
        ocd_state_type state;
        logic [7:0] raw0;
        logic [7:0] raw1;
        ocd_cfg_type cfg;
        logic valid;
        logic ack;
        logic refused;
        logic [7:0] rdata;
        logic nv_wr_en;
        logic nv_wr_sel;
        logic [7:0] nv_wr_data;
        logic nv_opt_erase;
        logic mem_erase;
        logic [7:0] fill;
    } ocd_main_state_type;

    // Value during and just after reset.
    localparam ocd_main_state_type RESET_STATE = '{
        state: ST_LOAD,
        raw0: CFG0_RESET,
        raw1: CFG1_RESET,
        cfg: CFG_DEFAULT,
        fill: MEM_BLANK_BYTE,
        default: '0
    };

    logic rst_sync_n; // Reset after the release chain.
    ocd_main_state_type state_reg; // Registered state.
    ocd_main_state_type state_next; // Next state.
    logic wrp_now; // Write protect as the cells hold it now or as loaded at reset.
    logic rdp_now; // Read-out protect as the cells hold it now.

    // Releases reset two edges after the pin goes high.
    ocd_reset_sync u_reset_sync (
        .i_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .o_rst_n(rst_sync_n)
    );

    // ==========================================================
    // Protection seen by the programming port
    // ==========================================================

    // A bit just programmed must take hold at once, not at next reset.
    assign wrp_now = i_nv_byte0[CFG0_WRP_BIT] | state_reg.cfg.wrp;
    assign rdp_now = i_nv_byte0[CFG0_RDP_BIT];

    // ==========================================================
    // Sequencer
    // ==========================================================

    // Fills the next state; pulse outputs fall back to zero each cycle.
    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.refused = 1'b0;
        state_next.nv_wr_en = 1'b0;
        state_next.nv_opt_erase = 1'b0;
        state_next.mem_erase = 1'b0;
        state_next.fill = MEM_BLANK_BYTE;
        unique case (state_reg.state)
            // Takes one copy of the cells right after reset.
            ST_LOAD: begin
                state_next.raw0 = i_nv_byte0;
                state_next.raw1 = i_nv_byte1;
                state_next.cfg = ocd_decode(i_nv_byte0, i_nv_byte1);
                state_next.valid = 1'b1;
                state_next.state = ST_RUN;
            end
            // Serves the programming port; settings stay untouched.
            ST_RUN: begin
                if (i_opt_req) begin
                    if (!i_prog_mode) begin
                        // Outside programming mode every access is refused.
                        state_next.ack = 1'b1;
                        state_next.refused = 1'b1;
                        state_next.rdata = 8'h00;
                    end else if ((i_opt_erase || i_opt_we) && wrp_now) begin
                        // Write protect locks the cells for good.
                        state_next.ack = 1'b1;
                        state_next.refused = 1'b1;
                    end else if (i_opt_erase && rdp_now) begin
                        // Protected content goes first, then the options.
                        state_next.mem_erase = 1'b1;
                        state_next.state = ST_MEM_ERASE;
                    end else if (i_opt_erase) begin
                        // Unprotected erase of both option bytes.
                        state_next.nv_opt_erase = 1'b1;
                        state_next.state = ST_NV_BUSY;
                    end else if (i_opt_we) begin
                        // Program one byte into the cells.
                        state_next.nv_wr_en = 1'b1;
                        state_next.nv_wr_sel = i_opt_sel;
                        state_next.nv_wr_data = i_opt_wdata;
                        state_next.state = ST_NV_BUSY;
                    end else begin
                        // Read back the live cell contents.
                        state_next.ack = 1'b1;
                        state_next.rdata = (i_opt_sel == SEL_BYTE1) ? i_nv_byte1 : i_nv_byte0;
                    end
                end
            end
            // Waits for the whole program memory to be blank.
            ST_MEM_ERASE: begin
                if (i_nv_done) begin
                    state_next.nv_opt_erase = 1'b1;
                    state_next.state = ST_NV_BUSY;
                end
            end
            // Waits for the cells to finish a program or erase.
            ST_NV_BUSY: begin
                if (i_nv_done) begin
                    state_next.ack = 1'b1;
                    state_next.state = ST_RUN;
                end
            end
            default: begin
                state_next.state = ST_LOAD;
            end
        endcase
    end

    // Registers the whole state; reset gives constants only.
    always_ff @(posedge i_sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    // ==========================================================

    assign o_opt_ack = state_reg.ack;
    assign o_opt_refused = state_reg.refused;
    assign o_opt_rdata = state_reg.rdata;
    assign o_nv_wr_en = state_reg.nv_wr_en;
    assign o_nv_wr_sel = state_reg.nv_wr_sel;
    assign o_nv_wr_data = state_reg.nv_wr_data;
    assign o_nv_opt_erase = state_reg.nv_opt_erase;
    assign o_mem_erase = state_reg.mem_erase;
    assign o_mem_fill = state_reg.fill;
    assign o_config_valid = state_reg.valid;
    assign o_startup_clock_select = state_reg.cfg.clk_sel;
    assign o_resonator_range = state_reg.cfg.range;
    assign o_resonator_enable = state_reg.cfg.resonator_on;
    assign o_external_clock = state_reg.cfg.ext_clock;
    assign o_range_reserved = state_reg.cfg.range_rsv;
    assign o_low_voltage_detect_enable = state_reg.cfg.lvd_en;
    assign o_watchdog_always_on = state_reg.cfg.wdg_always;
    assign o_watchdog_halt_reset = state_reg.cfg.halt_rst;
    assign o_wakeup_clock_select = state_reg.cfg.wake_sel;
    assign o_boot_region_size = state_reg.cfg.boot_sel;
    assign o_boot_region_bytes = state_reg.cfg.boot_bytes;
    assign o_readout_protect = state_reg.cfg.rdp;
    assign o_program_write_protect = state_reg.cfg.wrp;
    assign o_mem_read_block = state_reg.cfg.rd_block;
    assign o_mem_write_block = state_reg.cfg.wr_block;

    // ==========================================================
    // Checks
    // ==========================================================

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_sync_n);

    // A request taken while the sequencer is idle.
    sequence s_req_taken;
        state_reg.state == ST_RUN && i_opt_req;
    endsequence

    // An erase that meets read-out protection but no write protection.
    sequence s_protected_erase;
        s_req_taken ##0 i_prog_mode && i_opt_erase && !wrp_now && rdp_now;
    endsequence

    // Memory erase pulse, then the sequencer still waits on the memory.
    sequence s_mem_then_opt;
        o_mem_erase && !o_nv_opt_erase ##1 state_reg.state == ST_MEM_ERASE;
    endsequence

    // Out of programming mode: refused answer with zero data.
    mode_gate_a: assert property (
        s_req_taken ##0 !i_prog_mode |=> o_opt_ack && o_opt_refused && o_opt_rdata == 8'h00
            && !o_nv_wr_en && !o_nv_opt_erase && !o_mem_erase)
        else $error("access outside programming mode not refused");

    // Write protect: neither program nor erase reaches the cells.
    write_lock_a: assert property (
        s_req_taken ##0 i_prog_mode && (i_opt_we || i_opt_erase) && wrp_now
            |=> o_opt_refused && !o_nv_wr_en && !o_nv_opt_erase && !o_mem_erase)
        else $error("write protected cells were altered");

    // Protected erase starts with program memory, never the options.
    erase_order_a: assert property (
        s_protected_erase |=> s_mem_then_opt)
        else $error("protected erase did not clear memory first");

    // Option erase follows memory completion by exactly one cycle.
    opt_after_mem_a: assert property (
        state_reg.state == ST_MEM_ERASE && i_nv_done
            |=> o_nv_opt_erase && !o_mem_erase && state_reg.state == ST_NV_BUSY)
        else $error("option erase not issued after memory erase");

    // Once loaded, no setting changes until the next reset.
    settings_hold_a: assert property (
        o_config_valid |=> o_config_valid && $stable(state_reg.cfg) && $stable(state_reg.raw0)
            && $stable(state_reg.raw1))
        else $error("settings changed without reset");

    // The load copies the cells seen on the load cycle.
    load_copy_a: assert property (
        state_reg.state == ST_LOAD |=> o_config_valid
            && state_reg.raw0 == $past(i_nv_byte0) && state_reg.raw1 == $past(i_nv_byte1))
        else $error("loaded bytes differ from the cells");

    // Clock, detector and watchdog fields follow the loaded byte one.
    byte1_fields_a: assert property (
        o_config_valid |-> o_startup_clock_select == state_reg.raw1[CFG1_CLK_HI:CFG1_CLK_LO]
            && o_low_voltage_detect_enable == !state_reg.raw1[CFG1_LVD_BIT]
            && o_watchdog_always_on == !state_reg.raw1[CFG1_WDG_TYPE_BIT]
            && o_watchdog_halt_reset == state_reg.raw1[CFG1_WATCHDOG_HALT_RESET_BIT])
        else $error("byte one decode wrong");

    // Wakeup clock, boot size and protection follow the loaded byte zero.
    byte0_fields_a: assert property (
        o_config_valid |-> o_wakeup_clock_select == state_reg.raw0[CFG0_WAKE_BIT]
            && o_boot_region_bytes == (BOOT_BASE_BYTES << state_reg.raw0[CFG0_BOOT_HI:CFG0_BOOT_LO])
            && o_mem_read_block == state_reg.raw0[CFG0_RDP_BIT]
            && o_mem_write_block == (state_reg.raw0[CFG0_RDP_BIT] | state_reg.raw0[CFG0_WRP_BIT]))
        else $error("byte zero decode wrong");

    // A resonator band is only claimed for a resonator start.
    resonator_band_a: assert property (
        o_resonator_enable |-> o_startup_clock_select == CLK_RESONATOR
            && o_resonator_range <= RANGE_WATCH && !o_external_clock)
        else $error("resonator band decode wrong");

    // A read answers in one cycle with the selected cell.
    read_back_a: assert property (
        s_req_taken ##0 i_prog_mode && !i_opt_we && !i_opt_erase |=> o_opt_ack && !o_opt_refused
            && o_opt_rdata == ($past(i_opt_sel) ? $past(i_nv_byte1) : $past(i_nv_byte0)))
        else $error("read back data wrong");

    // Blank fill value is fixed.
    blank_fill_a: assert property (
        s_req_taken |=> o_mem_fill == 8'hFF ##1 o_mem_fill == 8'hFF)
        else $error("blank fill value wrong");

endmodule // ocd_option_decoder

// ==== verification/ocd_nv_model.sv ====
// ==========================================================
// Non-volatile option cell model
// ==========================================================
// Holds the two option bytes. Each program or erase pulse from the
// block is answered by a done pulse after a chosen delay.
module ocd_nv_model
    import ocd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_preset,
    input wire logic [7:0] i_preset0,
    input wire logic [7:0] i_preset1,
    input wire logic [3:0] i_delay,
    input wire logic i_wr_en,
    input wire logic i_wr_sel,
    input wire logic [7:0] i_wr_data,
    input wire logic i_opt_erase,
    input wire logic i_mem_erase,
    output logic o_done,
    output logic [7:0] o_byte0,
    output logic [7:0] o_byte1
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] wait_reg = 5'h00; // Cycles left of the pending job.
    logic [1:0] job_reg = 2'h0; // 1 program, 2 option erase, 3 memory erase.
    logic sel_reg = 1'b0; // Byte chosen by the pending program.
    logic [7:0] data_reg = 8'h00; // Value of the pending program.
    initial o_done = 1'b0;
    // A job starts on its pulse and ends with one done pulse.
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_preset) begin
            o_byte0 <= i_preset0; // Reserved bits come in as ones.
            o_byte1 <= i_preset1;
            wait_reg <= 5'h00;
        end else if (i_wr_en || i_opt_erase || i_mem_erase) begin
            wait_reg <= {1'b0, i_delay} + 5'h01;
            job_reg <= i_mem_erase ? 2'h3 : (i_opt_erase ? 2'h2 : 2'h1);
            sel_reg <= i_wr_sel;
            data_reg <= i_wr_data;
        end else if (wait_reg == 5'h01) begin
            if (job_reg == 2'h1 && sel_reg) o_byte1 <= data_reg;
            if (job_reg == 2'h1 && !sel_reg) o_byte0 <= data_reg;
            if (job_reg == 2'h2) begin
                o_byte0 <= CFG0_RESET; // Erased cells read as delivered.
                o_byte1 <= CFG1_RESET;
            end
            o_done <= 1'b1;
            wait_reg <= 5'h00;
        end else if (wait_reg != 5'h00) begin
            wait_reg <= wait_reg - 5'h01;
        end
    end
endmodule // ocd_nv_model

// ==== verification/ocd_option_decoder_tb.sv ====
// ==========================================================
// Option decoder testbench
// ==========================================================
module ocd_option_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ocd_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, prog_mode = 1'b0, req = 1'b0, we = 1'b0, erase = 1'b0;
    logic sel = 1'b0, preset = 1'b0, done, ack, refused, nv_wr_en, nv_wr_sel, nv_opt_erase;
    logic mem_erase, valid, res_en, ext_clk, rsv, lvd_en, wdg_on, halt_rst, wake, rdp, wrp;
    logic rd_blk, wr_blk;
    logic [7:0] wdata = 8'h00, p0 = 8'hFC, p1 = 8'h3F, byte0, byte1, rdata, nv_wr_data, fill;
    logic [3:0] delay = 4'h0;
    logic [1:0] clk_sel, boot_sz;
    logic [2:0] range;
    logic [12:0] boot_bytes;
    int err_total = 0, checked = 0, cycles = 0, mems;
    logic refd;
    logic [7:0] rd;
    // Configurations: clock code and boot size step 3 down to 0, reserved bits ones.
    // Entry 0 starts on the internal RC and leaves both protection bits clear.
    logic [7:0] t0 [4] = '{8'h40, 8'hD6, 8'hA9, 8'hEE};
    logic [7:0] t1 [4] = '{8'h38, 8'h7D, 8'hBE, 8'hFB};
    always #2.5 clk = ~clk;
    ocd_option_decoder ocd_option_decoder_i (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_prog_mode(prog_mode), .i_opt_req(req), .i_opt_we(we), .i_opt_erase(erase),
        .i_opt_sel(sel), .i_opt_wdata(wdata), .i_nv_byte0(byte0), .i_nv_byte1(byte1),
        .i_nv_done(done), .o_opt_ack(ack), .o_opt_refused(refused), .o_opt_rdata(rdata),
        .o_nv_wr_en(nv_wr_en), .o_nv_wr_sel(nv_wr_sel), .o_nv_wr_data(nv_wr_data),
        .o_nv_opt_erase(nv_opt_erase), .o_mem_erase(mem_erase), .o_mem_fill(fill),
        .o_config_valid(valid), .o_startup_clock_select(clk_sel), .o_resonator_range(range),
        .o_resonator_enable(res_en), .o_external_clock(ext_clk), .o_range_reserved(rsv),
        .o_low_voltage_detect_enable(lvd_en), .o_watchdog_always_on(wdg_on),
        .o_watchdog_halt_reset(halt_rst), .o_wakeup_clock_select(wake),
        .o_boot_region_size(boot_sz), .o_boot_region_bytes(boot_bytes),
        .o_readout_protect(rdp), .o_program_write_protect(wrp), .o_mem_read_block(rd_blk),
        .o_mem_write_block(wr_blk));
    ocd_nv_model ocd_nv_model_i (.i_clk(clk), .i_preset(preset), .i_preset0(p0),
        .i_preset1(p1), .i_delay(delay), .i_wr_en(nv_wr_en), .i_wr_sel(nv_wr_sel),
        .i_wr_data(nv_wr_data), .i_opt_erase(nv_opt_erase), .i_mem_erase(mem_erase),
        .o_done(done), .o_byte0(byte0), .o_byte1(byte1));
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Presets the cells, resets for three cycles and waits for the loaded settings.
    task automatic do_reset(input logic [7:0] b0, input logic [7:0] b1);
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        preset <= 1'b1;
        p0 <= b0;
        p1 <= b1;
        repeat (2) @(posedge clk);
        #1;
        chk("valid in reset", 0, valid);
        chk("boot in reset", 13'h1000, boot_bytes);
        chk("fill", 8'hFF, fill);
        @(posedge clk);
        rst_n <= 1'b1;
        preset <= 1'b0;
        n = 0;
        while (valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("valid", 1, valid);
    endtask
    // One request of the programming port: one cycle of request, then a bounded wait.
    task automatic access(input logic w, input logic e, input logic s, input logic [7:0] d);
        int n;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        erase <= e;
        sel <= s;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        mems = 0;
        #1;
        while (ack !== 1'b1 && n < 200) begin
            if (mem_erase === 1'b1) mems++;
            @(posedge clk);
            #1;
            n++;
        end
        chk("ack", 1, ack);
        refd = refused;
        rd = rdata;
    endtask
    // Checks every decoded setting against the two loaded bytes.
    task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1);
        logic [1:0] c;
        logic [2:0] r;
        c = b1[7:6];
        r = b0[6:4];
        chk("clock", c, clk_sel);
        chk("range", r, range);
        chk("resonator", c == 2'h2 && r <= 3'h4, res_en);
        chk("external", c == 2'h3 || (c[1] && (r == 3'h5 || r == 3'h7)), ext_clk);
        chk("reserved", c[1] && r == 3'h6, rsv);
        chk("detector", !b1[2], lvd_en);
        chk("watchdog", !b1[1], wdg_on);
        chk("halt reset", b1[0], halt_rst);
        chk("wakeup", b0[7], wake);
        chk("boot size", b0[3:2], boot_sz);
        chk("boot bytes", 13'h0200 << b0[3:2], boot_bytes);
        chk("readout", b0[1], rdp);
        chk("read block", b0[1], rd_blk);
        chk("write protect", b0[0], wrp);
        chk("write block", b0[1] | b0[0], wr_blk);
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            $display("Error timeout expected 0 seen %0d", cycles);
            report_and_stop();
        end
    end
    // Main sequence.
    initial begin
        for (int i = 3; i >= 0; i--) begin
            do_reset(t0[i], t1[i]);
            check_cfg(t0[i], t1[i]);
        end
        $display("test decode done");
        access(0, 0, 0, 8'h00);
        chk("mode refused", 1, refd);
        chk("mode rdata", 8'h00, rd);
        prog_mode <= 1'b1;
        access(0, 0, 1, 8'h00);
        chk("read refused", 0, refd);
        chk("read byte one", 8'h38, rd);
        delay <= 4'h9;
        access(1, 0, 0, 8'hC2);
        chk("program refused", 0, refd);
        access(0, 0, 0, 8'h00);
        chk("read back", 8'hC2, rd);
        check_cfg(8'h40, 8'h38);
        $display("test access done");
        access(0, 1, 0, 8'h00);
        chk("memory erased first", 1, mems);
        chk("protected erase refused", 0, refd);
        chk("cells erased", 8'hFC, byte0);
        delay <= 4'h0;
        access(0, 1, 0, 8'h00);
        chk("plain erase memory", 0, mems);
        $display("test erase done");
        access(1, 0, 0, 8'hC1);
        access(1, 0, 1, 8'h3B);
        chk("program refused", 1, refd);
        access(0, 1, 0, 8'h00);
        chk("erase refused", 1, refd);
        chk("erase memory", 0, mems);
        chk("cells kept", 8'hC1, byte0);
        chk("byte one kept", 8'h3F, byte1);
        $display("test protect done");
        report_and_stop();
    end
endmodule // ocd_option_decoder_tb
